/* File: core/pcif_pkg.sv */
package pcif_pkg;

    localparam int          PCIF_PINS      = 6;
    localparam int          PCIF_AW        = 12;

    // register byte offsets
    localparam logic [11:0] PCIF_OFS_RISE  = 12'h000;
    localparam logic [11:0] PCIF_OFS_FALL  = 12'h004;
    localparam logic [11:0] PCIF_OFS_PREQ  = 12'h008;
    localparam logic [11:0] PCIF_OFS_PFLAG = 12'h00C;
    localparam logic [11:0] PCIF_OFS_ISTAT = 12'h010;
    localparam logic [11:0] PCIF_OFS_IMASK = 12'h014;

    // peripheral request register field positions
    localparam int          PCIF_BIT_TMR   = 5;
    localparam int          PCIF_BIT_SUM   = 4;
    localparam int          PCIF_BIT_EXT   = 0;

    // sticky status / mask layout
    localparam int          PCIF_ST_CHG    = 0;
    localparam int          PCIF_ST_TMR    = 1;
    localparam int          PCIF_ST_EXT    = 2;
    localparam int          PCIF_ST_W      = 3;

    localparam logic [5:0]  PCIF_EN_RST    = 6'h00;
    localparam logic [5:0]  PCIF_FLAG_RST  = 6'h00;
    localparam logic [2:0]  PCIF_ST_RST    = 3'h0;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pcif_apb_req_s;

    typedef struct packed {
        logic        tmr_ovf;
        logic        ext_int;
    } pcif_evt_s;

endpackage : pcif_pkg

/* File: core/pcif_top.sv */
// Overview of operation
// (R1) enabled rising edge on a pin sets its change flag and summary
// (R2) enabled falling edge on a pin sets its change flag and summary
// (R3) disabled edges cause nothing; enables reset to zero, bits 7:6 read 0
// (R4) request register: timer bit 5, summary bit 4, external bit 0
// (R5) flags set regardless of the interrupt mask; pin flags still need their edge enable
// (R6) software clears stale flags before enabling an interrupt
// (R7) summary is OR of pin flags, read only
`timescale 1ns/1ps
`default_nettype none
module pcif_top (
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire pcif_pkg::pcif_apb_req_s apb,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    input  wire logic [5:0]             port_pin,
    input  wire pcif_pkg::pcif_evt_s    evt,
    output logic                        irq
);
    import pcif_pkg::*;

    logic [5:0]        sync1;
    logic [5:0]        sync2;
    logic [5:0]        pin_prev;
    logic [5:0]        pin_rise_enable;
    logic [5:0]        pin_fall_enable;
    logic [5:0]        pin_change_flag;
    logic              timer_overflow_flag;
    logic              ext_int_flag;
    logic [PCIF_ST_W-1:0] istat;
    logic [PCIF_ST_W-1:0] imask;
    logic [5:0]        next_rise;
    logic [5:0]        next_fall;
    logic [5:0]        next_flag;
    logic              next_tmr;
    logic              next_ext;
    logic [PCIF_ST_W-1:0] next_istat;
    logic [PCIF_ST_W-1:0] next_imask;
    logic              next_pready;
    logic [31:0]       next_prdata;
    logic              next_pslverr;
    logic              next_irq;
    logic [5:0]        edge_hit;
    logic              wr;
    logic              rd;
    logic              hit;
    logic              change_summary_flag;

    function automatic logic [31:0] zext6(input logic [5:0] v);
        zext6 = {26'h0000000, v};
    endfunction : zext6

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1    <= 6'h00;
            sync2    <= 6'h00;
            pin_prev <= 6'h00;
        end else begin
            sync1    <= port_pin;
            sync2    <= sync1;
            pin_prev <= sync2;
        end
    end

    assign change_summary_flag = |pin_change_flag;
    assign wr  = apb.psel & apb.penable & apb.pwrite & ~pready;
    assign rd  = apb.psel & apb.penable & ~apb.pwrite & ~pready;
    assign hit = apb.paddr == PCIF_OFS_RISE || apb.paddr == PCIF_OFS_FALL ||
                 apb.paddr == PCIF_OFS_PREQ || apb.paddr == PCIF_OFS_PFLAG ||
                 apb.paddr == PCIF_OFS_ISTAT || apb.paddr == PCIF_OFS_IMASK;

    always_comb begin
        // (R1) rising edge detect
        // (R2) falling edge detect
        // (R3) enable gating
        edge_hit = (sync2 & ~pin_prev & pin_rise_enable) |
                   (~sync2 & pin_prev & pin_fall_enable);
        next_rise    = pin_rise_enable;
        next_fall    = pin_fall_enable;
        next_flag    = pin_change_flag;
        next_tmr     = timer_overflow_flag;
        next_ext     = ext_int_flag;
        next_istat   = istat;
        next_imask   = imask;
        next_pready  = apb.psel & apb.penable & ~pready;
        next_prdata  = 32'h00000000;
        next_pslverr = (wr | rd) & ~hit;
        if (wr) begin
            case (apb.paddr)
                PCIF_OFS_RISE:  next_rise = apb.pwdata[5:0];
                PCIF_OFS_FALL:  next_fall = apb.pwdata[5:0];
                PCIF_OFS_PREQ: begin
                    // (R7) summary not writable
                    next_tmr = apb.pwdata[PCIF_BIT_TMR];
                    next_ext = apb.pwdata[PCIF_BIT_EXT];
                end
                PCIF_OFS_PFLAG: next_flag = apb.pwdata[5:0];
                PCIF_OFS_IMASK: next_imask = apb.pwdata[PCIF_ST_W-1:0];
                default: ;
            endcase
        end
        if (rd) begin
            case (apb.paddr)
                PCIF_OFS_RISE:  next_prdata = zext6(pin_rise_enable);
                PCIF_OFS_FALL:  next_prdata = zext6(pin_fall_enable);
                PCIF_OFS_PREQ: begin
                    // (R4) request layout
                    next_prdata[PCIF_BIT_TMR] = timer_overflow_flag;
                    next_prdata[PCIF_BIT_SUM] = change_summary_flag;
                    next_prdata[PCIF_BIT_EXT] = ext_int_flag;
                end
                PCIF_OFS_PFLAG: next_prdata = zext6(pin_change_flag);
                PCIF_OFS_ISTAT: begin
                    next_prdata = {29'h00000000, istat};
                    next_istat  = '0;
                end
                PCIF_OFS_IMASK: next_prdata = {29'h00000000, imask};
                default: ;
            endcase
        end
        // (R5) set regardless of imask (pin flags gated by edge enables), set beats clear
        next_flag = next_flag | edge_hit;
        next_tmr  = next_tmr | evt.tmr_ovf;
        next_ext  = next_ext | evt.ext_int;
        next_istat[PCIF_ST_CHG] = next_istat[PCIF_ST_CHG] | (|edge_hit);
        next_istat[PCIF_ST_TMR] = next_istat[PCIF_ST_TMR] | evt.tmr_ovf;
        next_istat[PCIF_ST_EXT] = next_istat[PCIF_ST_EXT] | evt.ext_int;
        next_irq = |(next_istat & next_imask);
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            // (R3) enables reset to zero
            pin_rise_enable     <= PCIF_EN_RST;
            pin_fall_enable     <= PCIF_EN_RST;
            pin_change_flag     <= PCIF_FLAG_RST;
            timer_overflow_flag <= 1'b0;
            ext_int_flag        <= 1'b0;
            istat               <= PCIF_ST_RST;
            imask               <= PCIF_ST_RST;
            pready              <= 1'b0;
            prdata              <= 32'h00000000;
            pslverr             <= 1'b0;
            irq                 <= 1'b0;
        end else begin
            pin_rise_enable     <= next_rise;
            pin_fall_enable     <= next_fall;
            pin_change_flag     <= next_flag;
            timer_overflow_flag <= next_tmr;
            ext_int_flag        <= next_ext;
            istat               <= next_istat;
            imask               <= next_imask;
            pready              <= next_pready;
            prdata              <= next_prdata;
            pslverr             <= next_pslverr;
            irq                 <= next_irq;
        end
    end

endmodule : pcif_top
`default_nettype wire

/* File: tb/pcif_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module pcif_assertions (
    input wire logic                    mclk,
    input wire logic                    rstn,
    input wire pcif_pkg::pcif_apb_req_s apb,
    input wire logic                    pready,
    input wire logic [31:0]             prdata,
    input wire logic                    pslverr,
    input wire logic [5:0]              port_pin,
    input wire pcif_pkg::pcif_evt_s     evt,
    input wire logic                    irq
);
    import pcif_pkg::*;
    logic rd;
    assign rd = pready && !apb.pwrite;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence setup_s; apb.psel && !apb.penable; endsequence
    sequence wait_s; apb.penable && !pready; endsequence
    a_one_wait: assert property (setup_s |=> wait_s ##1 pready)
        else $error("answer not after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_unmap: assert property (pready && apb.paddr > PCIF_OFS_IMASK
        |-> pslverr) else $error("unmapped not refused");
    a_ok_mapped: assert property (pready && apb.paddr <= PCIF_OFS_IMASK
        |-> !pslverr) else $error("mapped refused");
    a_enable_width: assert property (rd && apb.paddr <= PCIF_OFS_FALL
        |-> prdata[31:6] == 26'h0) else $error("enable upper bits set");
    a_req_fields: assert property (rd && apb.paddr == PCIF_OFS_PREQ
        |-> prdata[31:6] == 26'h0 && prdata[3:1] == 3'h0)
        else $error("request reserved bits set");
endmodule : pcif_assertions
bind pcif_top pcif_assertions pcif_assertions_inst (.mclk(mclk),
    .rstn(rstn), .apb(apb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .port_pin(port_pin), .evt(evt), .irq(irq));
`default_nettype wire

/* File: tb/pcif_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pcif_pin_model (
    input  wire logic       mclk,
    input  wire logic [5:0] level,
    output var  logic [5:0] port_pin
);
    initial port_pin = 6'h00;
    always @(posedge mclk) port_pin <= level;
endmodule : pcif_pin_model
`default_nettype wire

/* File: tb/pin_change_interrupt_flags_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_change_interrupt_flags_tb;
    import pcif_pkg::*;
    logic          mclk = 1'b0;
    logic          rstn = 1'b0;
    pcif_apb_req_s apb  = '0;
    pcif_evt_s     evt  = '0;
    logic [5:0]    lvl  = 6'h00;
    logic [5:0]    port_pin;
    logic          pready, pslverr, irq, er;
    logic [31:0]   prdata, rd;
    int            mismatches = 0;
    int            checked    = 0;
    always #10 mclk = ~mclk;
    pcif_pin_model pcif_pin_model_inst (.mclk(mclk), .level(lvl),
        .port_pin(port_pin));
    pcif_top pcif_top_inst (.mclk(mclk), .rstn(rstn), .apb(apb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .port_pin(port_pin), .evt(evt), .irq(irq));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        apb.penable <= 1'b1;
        do @(negedge mclk); while (pready !== 1'b1 && n++ < 20);
        rd = prdata;
        er = pslverr;
        @(posedge mclk);
        apb <= '0;
    endtask : xfer
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rchk
    task automatic pins(input logic [5:0] v);
        lvl <= v;
        repeat (6) @(posedge mclk);
    endtask : pins
    task automatic finish_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        #20us;
        mismatches++;
        finish_test;
    end
    initial begin
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        rchk(PCIF_OFS_RISE, 32'h0);
        rchk(PCIF_OFS_FALL, 32'h0);
        xfer(1'b1, PCIF_OFS_RISE, 32'hFF);
        rchk(PCIF_OFS_RISE, 32'h3F);
        xfer(1'b1, PCIF_OFS_RISE, 32'h01);
        xfer(1'b1, PCIF_OFS_FALL, 32'h02);
        pins(6'h3F);
        rchk(PCIF_OFS_PFLAG, 32'h01);
        pins(6'h00);
        rchk(PCIF_OFS_PFLAG, 32'h03);
        xfer(1'b1, PCIF_OFS_PREQ, 32'h0);
        rchk(PCIF_OFS_PREQ, 32'h10);
        rchk(PCIF_OFS_ISTAT, 32'h1);
        xfer(1'b1, PCIF_OFS_PFLAG, 32'h0);
        rchk(PCIF_OFS_PREQ, 32'h0);
        @(posedge mclk);
        evt <= '{1'b1, 1'b1};
        @(posedge mclk);
        evt <= '0;
        rchk(PCIF_OFS_PREQ, 32'h21);
        check(irq, 1'b0);
        xfer(1'b1, PCIF_OFS_PREQ, 32'h0);
        rchk(PCIF_OFS_PREQ, 32'h0);
        xfer(1'b1, PCIF_OFS_IMASK, 32'h6);
        repeat (2) @(negedge mclk);
        check(irq, 1'b1);
        rchk(PCIF_OFS_ISTAT, 32'h6);
        repeat (2) @(negedge mclk);
        check(irq, 1'b0);
        rchk(12'h018, 32'h0);
        check(er, 1'b1);
        finish_test;
    end
endmodule : pin_change_interrupt_flags_tb
`default_nettype wire
